// *** cdv_regs.vh ***
/*
 * register offsets, field positions, reset values and timing counts for the
 * cc debounce period and bus supply control registers.
 * assumes a 100 mhz ref_clk and a byte-wide host register port.
 */
`ifndef CDV_REGS_VH
`define CDV_REGS_VH

// byte addresses of the two registers
`define CDV_ADDR_CC_DEBOUNCE_PERIOD      12'h832
`define CDV_ADDR_CTL_LO      12'h840
`define CDV_ADDR_CTL_HI      12'h841

// cc debounce period reset value, counted in 10 ms units
`define CDV_CC_DEBOUNCE_PERIOD_RST       8'h0f

// bus supply control field positions
`define CDV_BIT_BACKDRIVE    11
`define CDV_BIT_ILOW         10
`define CDV_OCMIN_HI         9
`define CDV_OCMIN_LO         8
`define CDV_BIT_DBACT        7
`define CDV_BIT_OCEN         6
`define CDV_DIS_HI           5
`define CDV_DIS_LO           4
`define CDV_BIT_FET2         3
`define CDV_BIT_FET1         2
`define CDV_CMP_HI           1
`define CDV_CMP_LO           0

// comparator control codes
`define CDV_CMP_OFF          2'h0
`define CDV_CMP_VBUS         2'h1
`define CDV_CMP_CFG0         2'h2
`define CDV_CMP_CFG1         2'h3

// discharge control codes
`define CDV_DIS_EITHER       2'h0
`define CDV_DIS_NONE         2'h1
`define CDV_DIS_THR          2'h2
`define CDV_DIS_TIME         2'h3

// overcurrent alert minimum hold: time in ms, clock period in ns
`define CDV_CLK_NS           10
`define CDV_HOLD_5MS         5
`define CDV_HOLD_10MS        10
`define CDV_HOLD_20MS        20
`define CDV_HOLD_30MS        30
`define CDV_NS_PER_MS        1000000
`define CDV_HOLD_W           22

`endif

// *** cdv_hold_timer.v ***
/*
 * minimum-hold stretcher for the active-low overcurrent alert.
 * assumes ref_clk at 100 mhz; the hold counts come from the top parameters.
 */
`timescale 1ns/10ps
`include "cdv_regs.vh"

module cdv_hold_timer #(
    parameter [`CDV_HOLD_W-1:0] C5  = 22'd500000,
    parameter [`CDV_HOLD_W-1:0] C10 = 22'd1000000,
    parameter [`CDV_HOLD_W-1:0] C20 = 22'd2000000,
    parameter [`CDV_HOLD_W-1:0] C30 = 22'd3000000
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_n,
    // control
    input  wire       stretch_en,
    input  wire [1:0] sel,
    input  wire       oc_raw,
    // alert level, high while asserted
    output reg        alert_q
);
    reg  [`CDV_HOLD_W-1:0] cnt_q;   // remaining hold cycles
    reg  [`CDV_HOLD_W-1:0] len;     // selected hold length

    // pick the hold count from the two-bit select
    always @* begin
        case (sel)
            2'h0:    len = C5;
            2'h1:    len = C10;
            2'h2:    len = C20;
            default: len = C30;
        endcase
    end

    // the alert stays up while the cause lasts and for the hold time after its start
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q   <= {`CDV_HOLD_W{1'b0}};
            alert_q <= 1'b0;
        end else if (oc_raw && !alert_q) begin
            cnt_q   <= stretch_en ? len : {`CDV_HOLD_W{1'b0}};
            alert_q <= 1'b1;
        end else if (cnt_q != {`CDV_HOLD_W{1'b0}}) begin
            cnt_q   <= cnt_q - 1'b1;
        end else begin
            alert_q <= oc_raw;
        end
    end
endmodule

// *** cdv_regs_top.v ***
/*
 * cc debounce period and bus supply control registers of a type-c port
 * controller, with the fet, discharge, comparator and alert logic they steer.
 * assumes a single-cycle byte register port on ref_clk from the host
 * interface (i2c or spi front end) and synchronous analog status inputs.
 */
//
// Contract
// - cc debounce period, 8 bits, resets 0fh
// - back-drive monitored only when bit 11 set
// - back-drive switches that cc fet off
// - bits 11,6 reset 1 in dfp; the code sets them only in standalone dfp
// - bit 10 gates supply-current-low during discharge
// - alert held minimum 5/10/20/30 ms; the code holds it only in standalone dfp, other modes get no minimum
// - bit 7 shows bus debouncer active
// - fet overcurrent monitored only with bit 6
// - discharge control acts only in dfp
// - discharge on pin that supplied vconn
// - discharge modes: either, none, threshold, time
// - timeout above limit flags discharge error
// - bit 3 drives fet2, ignored standalone
// - bit 2 drives fet1, ignored standalone
// - overcurrent error clears both fet bits
// - bits 1:0 route shared comparator
// - config pin sample done clears field
// - ufp standalone holds field at 01b
// - software reads bit 7, not field
`timescale 1ns/10ps
`include "cdv_regs.vh"

module cdv_regs_top #(
    parameter [`CDV_HOLD_W-1:0] HOLD5  = `CDV_HOLD_5MS  * `CDV_NS_PER_MS / `CDV_CLK_NS,
    parameter [`CDV_HOLD_W-1:0] HOLD10 = `CDV_HOLD_10MS * `CDV_NS_PER_MS / `CDV_CLK_NS,
    parameter [`CDV_HOLD_W-1:0] HOLD20 = `CDV_HOLD_20MS * `CDV_NS_PER_MS / `CDV_CLK_NS,
    parameter [`CDV_HOLD_W-1:0] HOLD30 = `CDV_HOLD_30MS * `CDV_NS_PER_MS / `CDV_CLK_NS
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // mode straps, steady after reset
    input  wire        standalone,
    input  wire        dfp_mode,
    // host register port
    input  wire [11:0] reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // analog and state inputs
    input  wire        cc1_backdrive,
    input  wire        cc2_backdrive,
    input  wire        fet_overcurrent,
    input  wire        oc_debounced,
    input  wire        bus_debouncer_active,
    input  wire        bus_discharging,
    input  wire        discharge_path_select,
    input  wire        cable_below_threshold,
    input  wire        discharge_timer_done,
    input  wire        sample_done,
    input  wire        sa_fet1_req,
    input  wire        sa_fet2_req,
    input  wire        bus_overcurrent,
    // outputs to the analog front end
    output reg         fet1_on,
    output reg         fet2_on,
    output reg         discharge_cc1,
    output reg         discharge_cc2,
    output reg         discharge_timer_run,
    output reg         cable_supply_discharge_error,
    output reg         supply_current_low_flag,
    output reg         cmp_enable,
    output reg  [1:0]  cmp_source,
    output reg         overcurrent_alert_n,
    output reg         backdrive_event,
    output reg         fet_oc_event,
    output reg  [7:0]  cc_debounce_out
);
    // states of the discharge sequencer, one-hot
    localparam [2:0] DS_IDLE = 3'b001;
    localparam [2:0] DS_RUN  = 3'b010;
    localparam [2:0] DS_DONE = 3'b100;

    reg  [7:0] cc_debounce_period_q;        // cc debounce period
    reg        bd_en_q;         // back-drive monitor enable
    reg        ilow_q;          // supply-current-low enable
    reg  [1:0] ocmin_q;         // alert minimum hold select
    reg        ocen_q;          // fet overcurrent monitor enable
    reg  [1:0] dis_q;           // discharge control
    reg        fet2_q;          // fet2 software enable
    reg        fet1_q;          // fet1 software enable
    reg  [1:0] cmp_q;           // comparator control
    reg  [2:0] ds_q;            // discharge sequencer state
    reg        last1_q;         // pin 1 was the last supplier
    reg        last2_q;         // pin 2 was the last supplier
    reg        init_q;          // reset release seen
    wire       alert;           // stretched alert level
    wire       ufp_sa;          // standalone ufp
    wire       dfp_sa;          // standalone dfp
    wire       on1;             // fet1 effective enable
    wire       on2;             // fet2 effective enable
    wire       oc_err;          // debounced overcurrent error
    wire       bd1;             // back-drive hit on a live pin 1
    wire       bd2;             // back-drive hit on a live pin 2
    wire [15:0] ctl_rd;         // control register read image

    assign ufp_sa = standalone && !dfp_mode;
    assign dfp_sa = standalone && dfp_mode;
    // standalone ignores software fet bits and uses the internal requests
    assign on1    = standalone ? sa_fet1_req : fet1_q;
    assign on2    = standalone ? sa_fet2_req : fet2_q;
    assign bd1    = bd_en_q && cc1_backdrive && on1;
    assign bd2    = bd_en_q && cc2_backdrive && on2;
    assign oc_err = ocen_q && oc_debounced;
    // read image; bit 7 reflects the live debouncer, field 1:0 forced in standalone ufp
    assign ctl_rd = {4'h0, bd_en_q, ilow_q, ocmin_q, bus_debouncer_active,
                     ocen_q, dis_q, fet2_q, fet1_q,
                     ufp_sa ? `CDV_CMP_VBUS : cmp_q};

    // byte-lane write decode
    function hit;
        input [11:0] a;
        input [11:0] b;
        begin
            hit = reg_wr && (a == b);
        end
    endfunction

    // register file with hardware side effects
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cc_debounce_period_q <= `CDV_CC_DEBOUNCE_PERIOD_RST;
            bd_en_q  <= 1'b0;
            ilow_q   <= 1'b0;
            ocmin_q  <= 2'h0;
            ocen_q   <= 1'b0;
            dis_q    <= `CDV_DIS_EITHER;
            fet2_q   <= 1'b0;
            fet1_q   <= 1'b0;
            cmp_q    <= `CDV_CMP_OFF;
            init_q   <= 1'b0;
        end else begin
            init_q <= 1'b1;
            // straps caught one cycle after release
            if (!init_q) begin
                bd_en_q <= dfp_sa;
                ocen_q  <= dfp_sa;
            end
            if (hit(reg_addr, `CDV_ADDR_CC_DEBOUNCE_PERIOD))
                cc_debounce_period_q <= reg_wdata;
            if (hit(reg_addr, `CDV_ADDR_CTL_HI)) begin
                bd_en_q <= reg_wdata[`CDV_BIT_BACKDRIVE-8];
                ilow_q  <= reg_wdata[`CDV_BIT_ILOW-8];
                ocmin_q <= reg_wdata[`CDV_OCMIN_HI-8:`CDV_OCMIN_LO-8];
            end
            if (hit(reg_addr, `CDV_ADDR_CTL_LO)) begin
                ocen_q <= reg_wdata[`CDV_BIT_OCEN];
                dis_q  <= reg_wdata[`CDV_DIS_HI:`CDV_DIS_LO];
                fet2_q <= reg_wdata[`CDV_BIT_FET2];
                fet1_q <= reg_wdata[`CDV_BIT_FET1];
                cmp_q  <= reg_wdata[`CDV_CMP_HI:`CDV_CMP_LO];
            end
            // hardware clears win over a coincident write
            if (oc_err) begin
                fet1_q <= 1'b0;
                fet2_q <= 1'b0;
            end
            if (bd1)
                fet1_q <= 1'b0;
            if (bd2)
                fet2_q <= 1'b0;
            if (sample_done && cmp_q[1])
                cmp_q <= `CDV_CMP_OFF;
        end
    end

    // remember which pin last supplied the cable
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            last1_q <= 1'b0;
            last2_q <= 1'b0;
        end else if (on1 || on2) begin
            last1_q <= on1;
            last2_q <= on2;
        end
    end

    // discharge sequencer: starts when the supplying fet turns off in standalone dfp
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ds_q                         <= DS_IDLE;
            discharge_cc1                <= 1'b0;
            discharge_cc2                <= 1'b0;
            discharge_timer_run          <= 1'b0;
            cable_supply_discharge_error <= 1'b0;
        end else begin
            case (ds_q)
                DS_IDLE: begin
                    discharge_timer_run <= 1'b0;
                    if (dfp_sa && dis_q != `CDV_DIS_NONE && !on1 && !on2
                        && (fet1_on || fet2_on)) begin
                        ds_q                         <= DS_RUN;
                        discharge_cc1                <= last1_q;
                        discharge_cc2                <= last2_q;
                        discharge_timer_run          <= 1'b1;
                        cable_supply_discharge_error <= 1'b0;
                    end
                end
                DS_RUN: begin
                    // threshold ends modes 00 and 10; time ends 00 and 11
                    if ((dis_q != `CDV_DIS_TIME && cable_below_threshold)
                        || (dis_q != `CDV_DIS_THR && discharge_timer_done)) begin
                        ds_q                         <= DS_DONE;
                        discharge_cc1                <= 1'b0;
                        discharge_cc2                <= 1'b0;
                        discharge_timer_run          <= 1'b0;
                        cable_supply_discharge_error <= !dis_q[1] && discharge_timer_done
                                                        && !cable_below_threshold;
                    end
                end
                DS_DONE: begin
                    ds_q <= DS_IDLE;
                end
                default: begin
                    ds_q <= DS_IDLE;
                end
            endcase
            if (oc_err)
                cable_supply_discharge_error <= 1'b1;
        end
    end

    // registered outputs and read data
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata               <= 8'h00;
            fet1_on                 <= 1'b0;
            fet2_on                 <= 1'b0;
            supply_current_low_flag <= 1'b0;
            cmp_enable              <= 1'b0;
            cmp_source              <= `CDV_CMP_OFF;
            backdrive_event         <= 1'b0;
            fet_oc_event            <= 1'b0;
            cc_debounce_out         <= `CDV_CC_DEBOUNCE_PERIOD_RST;
            overcurrent_alert_n     <= 1'b1;
        end else begin
            if (reg_rd) begin
                case (reg_addr)
                    `CDV_ADDR_CC_DEBOUNCE_PERIOD: reg_rdata <= cc_debounce_period_q;
                    `CDV_ADDR_CTL_LO: reg_rdata <= ctl_rd[7:0];
                    `CDV_ADDR_CTL_HI: reg_rdata <= ctl_rd[15:8];
                    default:          reg_rdata <= 8'h00;
                endcase
            end
            fet1_on                 <= on1 && !bd1 && !oc_err;
            fet2_on                 <= on2 && !bd2 && !oc_err;
            supply_current_low_flag <= ilow_q && standalone && bus_discharging
                                       && !discharge_path_select;
            cmp_source              <= ufp_sa ? `CDV_CMP_VBUS : cmp_q;
            cmp_enable              <= ufp_sa || (cmp_q != `CDV_CMP_OFF);
            backdrive_event         <= bd1 || bd2;
            fet_oc_event            <= ocen_q && fet_overcurrent;
            cc_debounce_out         <= cc_debounce_period_q;
            overcurrent_alert_n     <= !alert;
        end
    end

    // alert stretcher
    cdv_hold_timer #(
        .C5  (HOLD5),
        .C10 (HOLD10),
        .C20 (HOLD20),
        .C30 (HOLD30)
    ) u_hold (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .stretch_en (dfp_sa),
        .sel        (ocmin_q),
        .oc_raw     (bus_overcurrent),
        .alert_q    (alert)
    );
endmodule

// *** cdv_regs_top_chk.sv ***
/* assertions on the ports of the cc debounce and bus supply control block.
   assumes one ref_clk domain with sync active-low rst_n; bound below. */
`timescale 1ns/10ps
module cdv_regs_top_chk (
    // clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    // straps and host port
    input wire        standalone,
    input wire        dfp_mode,
    input wire [11:0] reg_addr,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    // status inputs
    input wire        cc1_backdrive,
    input wire        cc2_backdrive,
    input wire        fet_overcurrent,
    input wire        oc_debounced,
    input wire        bus_debouncer_active,
    input wire        bus_discharging,
    input wire        discharge_path_select,
    input wire        sample_done,
    // drive outputs
    input wire        cmp_enable,
    input wire [1:0]  cmp_source,
    input wire        supply_current_low_flag,
    input wire        overcurrent_alert_n,
    input wire        backdrive_event,
    input wire        fet_oc_event,
    input wire [7:0]  cc_debounce_out
);
    // single domain, reset disables all
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_PERIOD_WR: assert property (
        reg_wr && reg_addr == 12'h832 |-> ##2 cc_debounce_out == $past(reg_wdata, 2))
        else $error("period write lost");
    AST_DB_ACTIVE: assert property (
        reg_rd && reg_addr == 12'h840 |=> reg_rdata[7] == $past(bus_debouncer_active)) else $error("bit 7 wrong");
    AST_CMP_OFF: assert property (
        cmp_enable |-> cmp_source != 2'h0) else $error("comparator on with code 00");
    AST_ALERT_HOLD: assert property (
        $fell(overcurrent_alert_n) && standalone && dfp_mode |=> !overcurrent_alert_n [*3]) else $error("alert short");
    AST_ILOW: assert property (
        supply_current_low_flag |-> standalone && $past(bus_discharging) && !$past(discharge_path_select))
        else $error("current low flag without cause");
    AST_BACKDRIVE: assert property (
        $rose(backdrive_event) |-> $past(cc1_backdrive || cc2_backdrive)) else $error("back-drive event uncaused");
    AST_SAMPLE_CLR: assert property (
        sample_done && cmp_enable && cmp_source[1] |-> ##[1:2] !cmp_enable) else $error("sample did not clear");
    AST_FET_OC: assert property (
        $rose(fet_oc_event) |-> $past(fet_overcurrent || oc_debounced)) else $error("fet oc event uncaused");
    AST_UFP_FIELD: assert property (
        standalone && !dfp_mode && reg_rd && reg_addr == 12'h840 |=> reg_rdata[1:0] == 2'h1)
        else $error("ufp field not 01");
endmodule

bind cdv_regs_top cdv_regs_top_chk chk_u (.ref_clk, .rst_n, .standalone, .dfp_mode, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .cc1_backdrive, .cc2_backdrive, .fet_overcurrent, .oc_debounced,
    .bus_debouncer_active, .bus_discharging, .discharge_path_select, .sample_done, .cmp_enable, .cmp_source,
    .supply_current_low_flag, .overcurrent_alert_n, .backdrive_event, .fet_oc_event, .cc_debounce_out);

// *** cdv_host_model.sv ***
/* companion processor model on the byte register port.
   assumes the block takes a strobe at the rising ref_clk edge. */
`timescale 1ns/10ps
module cdv_host_model (
    // clock
    input  wire        ref_clk,
    // register port
    output reg  [11:0] reg_addr,
    output reg         reg_wr,
    output reg         reg_rd,
    output reg  [7:0]  reg_wdata,
    input  wire [7:0]  reg_rdata
);
    // idle port from time zero
    initial begin
        reg_addr = 12'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // one write, strobe held over one rising edge
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(negedge ref_clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge ref_clk);
            reg_wr = 1'b0;
            reg_wdata = ~d;
        end
    endtask
    // one read, data registered at the strobe edge
    task rd(input [11:0] a, output [7:0] d);
        begin
            @(negedge ref_clk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge ref_clk);
            reg_rd = 1'b0;
            d = reg_rdata;
        end
    endtask
    // poll until the bus debouncer reports idle, bounded
    task wait_db_idle;
        reg [7:0] v;
        integer   n;
        begin
            v = 8'h80;
            for (n = 0; n < 50 && v[7] !== 1'b0; n = n + 1) rd(12'h840, v);
        end
    endtask
endmodule

// *** test_cdv_regs_top.sv ***
/* self-checking bench for the cc debounce and bus supply control block.
   assumes the host model drives the register port; hold counts shortened. */
`timescale 1ns/10ps
module test_cdv_regs_top;
    reg         ref_clk = 1'b0, rst_n = 1'b0, standalone = 1'b0, dfp_mode = 1'b0;
    reg         cc1_backdrive = 1'b0, cc2_backdrive = 1'b0, fet_overcurrent = 1'b0, oc_debounced = 1'b0;
    reg         bus_debouncer_active = 1'b0, bus_discharging = 1'b0, discharge_path_select = 1'b0;
    reg         cable_below_threshold = 1'b0, discharge_timer_done = 1'b0, sample_done = 1'b0;
    reg         sa_fet1_req = 1'b0, sa_fet2_req = 1'b0, bus_overcurrent = 1'b0;
    wire [11:0] reg_addr;
    wire [7:0]  reg_wdata, reg_rdata, cc_debounce_out;
    wire [1:0]  cmp_source;
    wire        reg_wr, reg_rd, fet1_on, fet2_on, cable_supply_discharge_error, supply_current_low_flag;
    wire        cmp_enable, overcurrent_alert_n, backdrive_event, fet_oc_event;
    wire        discharge_cc1, discharge_cc2, discharge_timer_run;
    integer     mismatches = 0, n_checks = 0, i, n;
    reg  [7:0]  rv;
    // 100 mhz clock
    always #5 ref_clk = ~ref_clk;
    cdv_host_model host_u (.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    cdv_regs_top #(.HOLD5(22'd5), .HOLD10(22'd10), .HOLD20(22'd20), .HOLD30(22'd30)) dut_u (
        .ref_clk, .rst_n, .standalone, .dfp_mode, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .cc1_backdrive, .cc2_backdrive, .fet_overcurrent, .oc_debounced, .bus_debouncer_active,
        .bus_discharging, .discharge_path_select, .cable_below_threshold, .discharge_timer_done, .sample_done,
        .sa_fet1_req, .sa_fet2_req, .bus_overcurrent, .fet1_on, .fet2_on, .discharge_cc1, .discharge_cc2,
        .discharge_timer_run, .cable_supply_discharge_error, .supply_current_low_flag, .cmp_enable,
        .cmp_source, .overcurrent_alert_n, .backdrive_event, .fet_oc_event, .cc_debounce_out);
    // compare and count
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("unexpected %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // reset held 20 cycles with the given straps
    task do_reset(input sa, input dfp);
        begin
            @(negedge ref_clk);
            rst_n = 1'b0;
            standalone = sa;
            dfp_mode = dfp;
            repeat (20) @(negedge ref_clk);
            rst_n = 1'b1;
            repeat (2) @(negedge ref_clk);
        end
    endtask
    // companion reset values, period register, unmapped and read-only places
    task t_reset_vals;
        begin
            host_u.rd(12'h832, rv); chk("period_rst", rv, 8'h0f);
            chk("period_out", cc_debounce_out, 8'h0f);
            host_u.rd(12'h840, rv); chk("ctl_lo_rst", rv, 8'h00);
            host_u.rd(12'h841, rv); chk("ctl_hi_rst", rv, 8'h00);
            host_u.rd(12'h800, rv); chk("unmapped", rv, 8'h00);
            host_u.wr(12'h832, 8'ha5);
            host_u.rd(12'h832, rv); chk("period_rw", rv, 8'ha5);
            chk("period_out", cc_debounce_out, 8'ha5);
            bus_debouncer_active = 1'b1;
            host_u.wr(12'h840, 8'h80);
            host_u.rd(12'h840, rv); chk("db_active_1", rv, 8'h80);
            bus_debouncer_active = 1'b0;
            host_u.wait_db_idle;
            host_u.rd(12'h840, rv); chk("db_active_0", rv, 8'h00);
            $display("test reset_values done");
        end
    endtask
    // fet control and automatic clear on debounced overcurrent
    task t_fet_oc;
        begin
            host_u.wr(12'h840, 8'h4c);
            repeat (2) @(negedge ref_clk);
            chk("fet1_on", fet1_on, 1);
            chk("fet2_on", fet2_on, 1);
            oc_debounced = 1'b1;
            fet_overcurrent = 1'b1;
            repeat (2) @(negedge ref_clk);
            oc_debounced = 1'b0;
            fet_overcurrent = 1'b0;
            repeat (3) @(negedge ref_clk);
            chk("fet1_oc", fet1_on, 0);
            chk("fet2_oc", fet2_on, 0);
            chk("dis_err", cable_supply_discharge_error, 1);
            host_u.rd(12'h840, rv); chk("fet_bits", rv, 8'h40);
            $display("test fet_overcurrent done");
        end
    endtask
    // back-drive ignored while disabled, switches the fet off when enabled
    task t_backdrive;
        begin
            host_u.wr(12'h841, 8'h00);
            host_u.wr(12'h840, 8'h04);
            cc1_backdrive = 1'b1;
            repeat (3) @(negedge ref_clk);
            chk("bd_off_fet1", fet1_on, 1);
            cc1_backdrive = 1'b0;
            host_u.wr(12'h841, 8'h08);
            cc1_backdrive = 1'b1;
            @(negedge ref_clk);
            chk("bd_event", backdrive_event, 1);
            repeat (2) @(negedge ref_clk);
            chk("bd_on_fet1", fet1_on, 0);
            cc1_backdrive = 1'b0;
            $display("test backdrive done");
        end
    endtask
    // every comparator code, with self clear after a config pin sample
    task t_comparator;
        begin
            for (i = 1; i < 4; i = i + 1) begin
                host_u.wr(12'h840, i[7:0]);
                repeat (2) @(negedge ref_clk);
                chk("cmp_source", cmp_source, i[7:0]);
                chk("cmp_enable", cmp_enable, 1);
                sample_done = 1'b1;
                @(negedge ref_clk);
                sample_done = 1'b0;
                repeat (2) @(negedge ref_clk);
                host_u.rd(12'h840, rv); chk("cmp_field", rv & 8'h03, (i == 1) ? 8'h01 : 8'h00);
                chk("cmp_after", cmp_enable, (i == 1) ? 8'h01 : 8'h00);
            end
            host_u.wr(12'h840, 8'h00);
            repeat (2) @(negedge ref_clk);
            chk("cmp_off", cmp_enable, 0);
            $display("test comparator done");
        end
    endtask
    // standalone dfp: reset enables, alert hold, current low flag
    task t_dfp;
        begin
            do_reset(1'b1, 1'b1);
            host_u.rd(12'h841, rv); chk("dfp_hi_rst", rv, 8'h08);
            host_u.rd(12'h840, rv); chk("dfp_bit6", rv & 8'h40, 8'h40);
            host_u.wr(12'h841, 8'h09);
            bus_overcurrent = 1'b1;
            @(negedge ref_clk);
            bus_overcurrent = 1'b0;
            for (n = 0; n < 8 && overcurrent_alert_n === 1'b1; n = n + 1) @(negedge ref_clk);
            for (n = 0; n < 200 && overcurrent_alert_n === 1'b0; n = n + 1) @(negedge ref_clk);
            chk("alert_hold", n >= 10, 1);
            host_u.wr(12'h841, 8'h0c);
            bus_discharging = 1'b1;
            repeat (3) @(negedge ref_clk);
            chk("ilow_on", supply_current_low_flag, 1);
            discharge_path_select = 1'b1;
            repeat (3) @(negedge ref_clk);
            chk("ilow_path", supply_current_low_flag, 0);
            discharge_path_select = 1'b0;
            host_u.wr(12'h841, 8'h08);
            repeat (3) @(negedge ref_clk);
            chk("ilow_off", supply_current_low_flag, 0);
            bus_discharging = 1'b0;
            sa_fet1_req = 1'b1;
            @(negedge ref_clk);
            sa_fet1_req = 1'b0;
            discharge_timer_done = 1'b1;
            @(negedge ref_clk);
            chk("dis_cc1", discharge_cc1, 1);
            chk("dis_run", discharge_timer_run, 1);
            @(negedge ref_clk);
            chk("dis_end", discharge_cc1, 0);
            chk("dis_err", cable_supply_discharge_error, 1);
            host_u.wr(12'h840, 8'h60);
            sa_fet2_req = 1'b1;
            @(negedge ref_clk);
            sa_fet2_req = 1'b0;
            repeat (2) @(negedge ref_clk);
            chk("thr_cc2", discharge_cc2, 1);
            cable_below_threshold = 1'b1;
            @(negedge ref_clk);
            chk("thr_end", discharge_cc2, 0);
            chk("thr_err", cable_supply_discharge_error, 0);
            discharge_timer_done = 1'b0;
            cable_below_threshold = 1'b0;
            $display("test standalone_dfp done");
        end
    endtask
    // standalone ufp: forced comparator field, fet bits ignored
    task t_ufp;
        begin
            do_reset(1'b1, 1'b0);
            host_u.rd(12'h841, rv); chk("ufp_hi_rst", rv, 8'h00);
            host_u.wr(12'h840, 8'h0c);
            host_u.rd(12'h840, rv); chk("ufp_field", rv & 8'h03, 8'h01);
            chk("ufp_fet1", fet1_on, 0);
            chk("ufp_fet2", fet2_on, 0);
            sa_fet1_req = 1'b1;
            repeat (3) @(negedge ref_clk);
            chk("ufp_sa_fet1", fet1_on, 1);
            sa_fet1_req = 1'b0;
            $display("test standalone_ufp done");
        end
    endtask
    // verdict and end of run
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // hang guard
    initial begin
        #300000;
        mismatches = mismatches + 1;
        wrap_up;
    end
    // main sequence
    initial begin
        do_reset(1'b0, 1'b0);
        t_reset_vals;
        t_fet_oc;
        t_backdrive;
        t_comparator;
        t_dfp;
        t_ufp;
        wrap_up;
    end
endmodule
